// ---- core/dpbrf_map.vh ----
/*
 * Constants of the dual-port block memory tile: register offsets, field
 * positions, reset values, capacities and write policy codes.
 * Assumes it is included by bare name from the core file.
 */
`ifndef DPBRF_MAP_VH
`define DPBRF_MAP_VH

// Register offsets (byte addresses)
`define DPBRF_CTRL_OFS 8'h00
`define DPBRF_WIDTH_OFS 8'h04
`define DPBRF_AFULL_OFS 8'h08
`define DPBRF_AEMPTY_OFS 8'h0c
`define DPBRF_STATUS_OFS 8'h10
`define DPBRF_FILL_OFS 8'h14

// Control field positions
`define DPBRF_C_SPLIT 0
`define DPBRF_C_FIFO 1
`define DPBRF_C_WIDE 2
`define DPBRF_C_OREG 3
`define DPBRF_C_POLA 4
`define DPBRF_C_POLB 6
`define DPBRF_C_NOLATCH 8
`define DPBRF_C_ECC 9
`define DPBRF_C_CMEM 10
`define DPBRF_C_CPOS 11
`define DPBRF_C_FCIN 12
`define DPBRF_C_FCOUT 13
`define DPBRF_C_FRST 14

// Width register field positions
`define DPBRF_W_A 0
`define DPBRF_W_B 4

// Reset values
`define DPBRF_CTRL_RST 15'h0000
`define DPBRF_WIDTH_RST 7'h55
`define DPBRF_AFULL_RST 16'h8000
`define DPBRF_AEMPTY_RST 16'h0048

// Write policies
`define DPBRF_POL_OLD 2'h0
`define DPBRF_POL_NEW 2'h1
`define DPBRF_POL_HOLD 2'h2

// Capacities in bits, words of the array
`define DPBRF_CAP_FULL 17'h09000
`define DPBRF_CAP_HALF 17'h04800
`define DPBRF_WORD_BITS 17'h00048
`define DPBRF_WORDS 512

`endif

// ---- core/dpbrf_core.v ----
/*
 * Dual-port 36Kb block memory tile with split halves, aspect ratios,
 * one-read-one-write wide mode, SECDED protection, FIFO controller and
 * cascade paths, configured over a plain register port.
 * Assumes one clock for everything and inputs synchronous to it.
 */
// What this block does
// RULE1 - 36Kb array, two independent ports
// RULE2 - Whole 36Kb or two independent 18Kb halves
// RULE3 - All accesses on rising clock edge
// RULE4 - Inputs registered, address held unless unlatched
// RULE5 - Optional output register adds one cycle
// RULE6 - Write output policy: old, new, hold
// RULE7 - Cascade data between neighbouring tiles
// RULE8 - Dedicated power gating input
// RULE9 - Full tile shapes 32Kx1 to 512x72
// RULE10 - Ports take different shapes freely
// RULE11 - Half tile shapes 16Kx1 to 512x36
// RULE12 - Wide widths only in one-read-one-write mode
// RULE13 - Wide mode fixes one side wide
// RULE14 - Eight check bits, correct single, detect double
// RULE15 - Codec usable for external wide memory
// RULE16 - FIFO of 36Kb or 18Kb
// RULE17 - FIFO advances addresses by itself
// RULE18 - Full, empty, almost full, almost empty
// RULE19 - User thresholds drive almost flags
// RULE20 - FIFO widths differ per side
// RULE21 - Dedicated FIFO cascade chain
// RULE22 - Single and double error indications
// RULE23 - Pointers synchronised, flags per side
`timescale 1ns/1ns
`include "dpbrf_map.vh"
`default_nettype none

module dpbrf_core (
  // Clock and reset
  input wire ref_clk_i,
  input wire rstn_i,
  // Register port
  input wire [7:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [31:0] reg_rdata_o,
  // Power gating
  input wire pwr_gate_i,
  output reg sleep_o,
  // Port A, write side in FIFO mode
  input wire a_en_i,
  input wire a_we_i,
  input wire [15:0] a_addr_i,
  input wire [71:0] a_din_i,
  output reg [71:0] a_dout_o,
  output reg a_sbe_o,
  output reg a_dbe_o,
  // Port B, read side in FIFO mode
  input wire b_en_i,
  input wire b_we_i,
  input wire [15:0] b_addr_i,
  input wire [71:0] b_din_i,
  output reg [71:0] b_dout_o,
  output reg b_sbe_o,
  output reg b_dbe_o,
  // FIFO flags
  output reg full_o,
  output reg empty_o,
  output reg afull_o,
  output reg aempty_o,
  // Cascade
  input wire [71:0] casc_a_i,
  input wire [71:0] casc_b_i,
  output reg [71:0] casc_a_o,
  output reg [71:0] casc_b_o,
  input wire casc_fwr_i,
  output reg casc_fwr_o,
  input wire casc_frdy_i,
  output reg casc_frdy_o,
  // Stand-alone check-bit codec
  input wire [63:0] ecc_enc_d_i,
  output reg [7:0] ecc_enc_c_o,
  input wire [71:0] ecc_dec_i,
  output reg [63:0] ecc_dec_o,
  output reg ecc_dec_sbe_o,
  output reg ecc_dec_dbe_o
);

////////////////////////////////////////////////////////////////////////////
// Functions

// Width code to bits, clamped to a maximum
function [6:0] wdc;
  input [2:0] code;
  input [6:0] wmax;
  reg [6:0] w;
  begin
    case (code)
      3'h0: w = 7'h01;
      3'h1: w = 7'h02;
      3'h2: w = 7'h04;
      3'h3: w = 7'h09;
      3'h4: w = 7'h12;
      3'h5: w = 7'h24;
      default: w = 7'h48;
    endcase
    wdc = (w > wmax) ? wmax : w;
  end
endfunction

// Bit position of an address within the tile
function [16:0] bitpos;
  input [15:0] addr;
  input [6:0] w;
  input [16:0] cap;
  input half;
  reg [22:0] t;
  begin
    t = addr * w;
    t = t % {6'h00, cap};
    bitpos = t[16:0] + (half ? `DPBRF_CAP_HALF : 17'h00000);
  end
endfunction

// Merge w bits of din into a word at offset off
function [71:0] wmerge;
  input [71:0] old;
  input [71:0] din;
  input [6:0] off;
  input [6:0] w;
  integer i;
  begin
    wmerge = old;
    for (i = 0; i < 72; i = i + 1) begin
      if (i >= off && i < off + w) begin
        wmerge[i] = din[i - off];
      end
    end
  end
endfunction

// Take w bits at offset off, zero above
function [71:0] extract;
  input [71:0] word;
  input [6:0] off;
  input [6:0] w;
  integer i;
  begin
    extract = 72'h0;
    for (i = 0; i < 72; i = i + 1) begin
      if (i < w && i + off < 72) begin
        extract[i] = word[i + off];
      end
    end
  end
endfunction

// Check bits: seven Hamming bits plus overall parity
function [7:0] ecc_chk;
  input [63:0] d;
  integer i;
  integer j;
  reg [6:0] p;
  begin
    p = 7'h00;
    j = 0;
    for (i = 1; i < 72; i = i + 1) begin
      if ((i & (i - 1)) != 0) begin
        p = p ^ (d[j] ? i[6:0] : 7'h00);
        j = j + 1;
      end
    end
    ecc_chk = {^{d, p}, p};
  end
endfunction

// Decode: {dbe, sbe, corrected data}
function [65:0] ecc_dec;
  input [71:0] cw;
  reg [6:0] syn;
  reg [7:0] chk;
  reg [63:0] d;
  reg ov;
  integer i;
  integer j;
  begin
    d = cw[63:0];
    chk = ecc_chk(cw[63:0]);
    syn = chk[6:0] ^ cw[70:64];
    ov = ^cw;
    j = 0;
    for (i = 1; i < 72; i = i + 1) begin
      if ((i & (i - 1)) != 0) begin
        if (ov && i[6:0] == syn) begin
          d[j] = ~d[j];
        end
        j = j + 1;
      end
    end
    ecc_dec = {~ov & (syn != 7'h00), ov, d};
  end
endfunction

////////////////////////////////////////////////////////////////////////////
// Configuration registers

reg [14:0] ctrl;
reg [6:0] widths;
reg [15:0] thr_af;
reg [15:0] thr_ae;
reg [16:0] wptr;
reg [16:0] rptr;
reg [16:0] wcnt;

wire split = ctrl[`DPBRF_C_SPLIT];
wire fifo = ctrl[`DPBRF_C_FIFO];
wire wide = ctrl[`DPBRF_C_WIDE];
wire oreg = ctrl[`DPBRF_C_OREG];
wire nolatch = ctrl[`DPBRF_C_NOLATCH];
wire ecc_en = ctrl[`DPBRF_C_ECC];
wire cmem = ctrl[`DPBRF_C_CMEM];
wire fcin = ctrl[`DPBRF_C_FCIN];
wire fcout = ctrl[`DPBRF_C_FCOUT];

always @(posedge ref_clk_i or negedge rstn_i) begin
  if (!rstn_i) begin
    ctrl <= `DPBRF_CTRL_RST;
    widths <= `DPBRF_WIDTH_RST;
    thr_af <= `DPBRF_AFULL_RST;
    thr_ae <= `DPBRF_AEMPTY_RST;
    reg_rdata_o <= 32'h0;
  end else begin
    ctrl[`DPBRF_C_FRST] <= 1'b0;
    if (reg_wr_i) begin
      case (reg_addr_i)
        `DPBRF_CTRL_OFS: ctrl <= reg_wdata_i[14:0];
        `DPBRF_WIDTH_OFS: widths <= reg_wdata_i[6:0];
        `DPBRF_AFULL_OFS: thr_af <= reg_wdata_i[15:0]; // RULE19
        `DPBRF_AEMPTY_OFS: thr_ae <= reg_wdata_i[15:0]; // RULE19
        default: ;
      endcase
    end
    reg_rdata_o <= 32'h0;
    if (reg_rd_i) begin
      case (reg_addr_i)
        `DPBRF_CTRL_OFS: reg_rdata_o <= {17'h0, 1'b0, ctrl[13:0]};
        `DPBRF_WIDTH_OFS: reg_rdata_o <= {25'h0, widths};
        `DPBRF_AFULL_OFS: reg_rdata_o <= {16'h0, thr_af};
        `DPBRF_AEMPTY_OFS: reg_rdata_o <= {16'h0, thr_ae};
        `DPBRF_STATUS_OFS: reg_rdata_o <= {25'h0, sleep_o, b_dbe_o,
          b_sbe_o, aempty_o, afull_o, empty_o, full_o};
        `DPBRF_FILL_OFS: reg_rdata_o <= {15'h0, wcnt};
        default: reg_rdata_o <= 32'h0;
      endcase
    end
  end
end

////////////////////////////////////////////////////////////////////////////
// Port shapes and access decode

reg [71:0] mem [0:`DPBRF_WORDS-1]; // RULE1
wire [16:0] cap = split ? `DPBRF_CAP_HALF : `DPBRF_CAP_FULL; // RULE2 RULE16
wire [6:0] wmax = split ? 7'h24 : 7'h48;
wire [6:0] tdmax = split ? 7'h12 : 7'h24; // RULE12
// RULE9 RULE10 RULE11 RULE13 RULE20
wire [6:0] a_w = (wide & ~fifo) ? wmax :
  wdc(widths[2:0], fifo ? wmax : tdmax);
wire [6:0] b_w = wdc(widths[6:4], (wide | fifo) ? wmax : tdmax);
wire a_own = ~cmem | (a_addr_i[15] == ctrl[`DPBRF_C_CPOS]);
wire b_own = ~cmem | (b_addr_i[15] == ctrl[`DPBRF_C_CPOS]);
wire fwr_req = fcin ? casc_fwr_i : a_en_i; // RULE21
wire frd_req = fcout ? casc_frdy_i : b_en_i; // RULE21
wire fwr_ok = fifo & ~pwr_gate_i & fwr_req & ~full_o;
wire frd_ok = fifo & ~pwr_gate_i & frd_req & ~empty_o;
wire a_acc = ~fifo & ~pwr_gate_i & a_en_i & a_own; // RULE8
wire b_acc = ~fifo & ~pwr_gate_i & b_en_i & b_own; // RULE8
wire a_wr = fifo ? fwr_ok : a_acc & a_we_i;
wire a_rd = a_acc & ~a_we_i & ~wide; // RULE12
wire b_wr = b_acc & b_we_i & ~wide; // RULE12
wire b_rd = fifo ? frd_ok : b_acc & (~b_we_i | wide);
// RULE4
wire a_ref = nolatch & ~fifo & ~pwr_gate_i & ~a_acc;
wire b_ref = nolatch & ~fifo & ~pwr_gate_i & ~b_acc;
wire [16:0] wadr = (wptr >= cap) ? wptr - cap : wptr; // RULE17
wire [16:0] radr = (rptr >= cap) ? rptr - cap : rptr; // RULE17
wire [16:0] a_pos = fifo ? wadr : // RULE17
  bitpos({1'b0, a_addr_i[14:0]}, a_w, cap, 1'b0);
wire [16:0] b_pos = fifo ? radr :
  bitpos({1'b0, b_addr_i[14:0]}, b_w, cap, split & ~wide);
wire [16:0] a_q = a_pos / `DPBRF_WORD_BITS;
wire [16:0] b_q = b_pos / `DPBRF_WORD_BITS;
wire [16:0] a_r = a_pos % `DPBRF_WORD_BITS;
wire [16:0] b_r = b_pos % `DPBRF_WORD_BITS;
wire [8:0] a_word = a_q[8:0];
wire [8:0] b_word = b_q[8:0];
wire [6:0] a_off = a_r[6:0];
wire [6:0] b_off = b_r[6:0];
wire a_ecc = ecc_en & (a_w == 7'h48);
wire b_ecc = ecc_en & (b_w == 7'h48);
wire [71:0] a_src = (fifo & fcin) ? casc_b_i : a_din_i;
// RULE14
wire [71:0] a_wd = a_ecc ? {ecc_chk(a_src[63:0]), a_src[63:0]} : a_src;
wire [71:0] b_wd = b_ecc ? {ecc_chk(b_din_i[63:0]), b_din_i[63:0]} :
  b_din_i;
wire [71:0] a_old = extract(mem[a_word], a_off, a_w);
wire [71:0] b_old = extract(mem[b_word], b_off, b_w);
wire [65:0] a_dec = ecc_dec(a_old);
wire [65:0] b_dec = ecc_dec(b_old);

////////////////////////////////////////////////////////////////////////////
// Array, writes on the clock edge; B wins a same-word clash

always @(posedge ref_clk_i) begin
  if (a_wr) begin
    mem[a_word] <= wmerge(mem[a_word], a_wd, a_off, a_w); // RULE3
  end
  if (b_wr) begin
    mem[b_word] <= wmerge(mem[b_word], b_wd, b_off, b_w); // RULE3
  end
end

////////////////////////////////////////////////////////////////////////////
// Read data paths

reg [73:0] a_raw;
reg [73:0] b_raw;
reg [73:0] next_a_raw;
reg [73:0] next_b_raw;
reg a_sel;
reg b_sel;

always @* begin
  next_a_raw = a_raw;
  if (a_wr & ~fifo) begin
    case (ctrl[5:4]) // RULE6
      `DPBRF_POL_OLD: next_a_raw = {2'b00, a_old};
      `DPBRF_POL_NEW: next_a_raw = {2'b00, extract(a_wd, 7'h00, a_w)};
      default: next_a_raw = a_raw;
    endcase
  end else if (a_rd | a_ref) begin
    next_a_raw = a_ecc ? {a_dec[65:64], 8'h00, a_dec[63:0]} : // RULE22
      {2'b00, a_old};
  end
  next_b_raw = b_raw;
  if (b_wr) begin
    case (ctrl[7:6]) // RULE6
      `DPBRF_POL_OLD: next_b_raw = {2'b00, b_old};
      `DPBRF_POL_NEW: next_b_raw = {2'b00, extract(b_wd, 7'h00, b_w)};
      default: next_b_raw = b_raw;
    endcase
  end else if (b_rd | b_ref) begin
    next_b_raw = b_ecc ? {b_dec[65:64], 8'h00, b_dec[63:0]} : // RULE22
      {2'b00, b_old};
  end
end

always @(posedge ref_clk_i or negedge rstn_i) begin
  if (!rstn_i) begin
    a_raw <= 74'h0;
    b_raw <= 74'h0;
    a_sel <= 1'b1;
    b_sel <= 1'b1;
    a_dout_o <= 72'h0;
    b_dout_o <= 72'h0;
    {a_dbe_o, a_sbe_o} <= 2'b00;
    {b_dbe_o, b_sbe_o} <= 2'b00;
    casc_a_o <= 72'h0;
    casc_b_o <= 72'h0;
    sleep_o <= 1'b0;
  end else begin
    a_raw <= next_a_raw;
    b_raw <= next_b_raw;
    casc_a_o <= next_a_raw[71:0]; // RULE7
    casc_b_o <= next_b_raw[71:0]; // RULE7 RULE21
    if (a_en_i) begin
      a_sel <= a_own;
    end
    if (b_en_i) begin
      b_sel <= b_own;
    end
    sleep_o <= pwr_gate_i; // RULE8
    if (cmem) begin
      a_dout_o <= a_sel ? a_raw[71:0] : casc_a_i; // RULE7
      b_dout_o <= b_sel ? b_raw[71:0] : casc_b_i; // RULE7
      {a_dbe_o, a_sbe_o} <= a_sel ? a_raw[73:72] : 2'b00;
      {b_dbe_o, b_sbe_o} <= b_sel ? b_raw[73:72] : 2'b00;
    end else if (oreg) begin
      a_dout_o <= a_raw[71:0]; // RULE5
      b_dout_o <= b_raw[71:0]; // RULE5
      {a_dbe_o, a_sbe_o} <= a_raw[73:72];
      {b_dbe_o, b_sbe_o} <= b_raw[73:72];
    end else begin
      a_dout_o <= next_a_raw[71:0];
      b_dout_o <= next_b_raw[71:0];
      {a_dbe_o, a_sbe_o} <= next_a_raw[73:72];
      {b_dbe_o, b_sbe_o} <= next_b_raw[73:72];
    end
  end
end

////////////////////////////////////////////////////////////////////////////
// FIFO controller, counts in bits

reg [16:0] wptr_s1;
reg [16:0] wptr_s2;
reg [16:0] rptr_s1;
reg [16:0] rptr_s2;
wire [17:0] wsum = {1'b0, wptr} + {11'h0, a_w};
wire [17:0] rsum = {1'b0, rptr} + {11'h0, b_w};
// Pointers span twice the capacity so full differs from empty
wire [17:0] cap2 = {cap, 1'b0};
wire [17:0] wwrap = (wsum >= cap2) ? wsum - cap2 : wsum;
wire [17:0] rwrap = (rsum >= cap2) ? rsum - cap2 : rsum;
wire [16:0] next_wptr = fwr_ok ? wwrap[16:0] : wptr; // RULE17
wire [16:0] next_rptr = frd_ok ? rwrap[16:0] : rptr; // RULE17
wire [17:0] wdiff = {1'b0, next_wptr} - {1'b0, rptr_s2} +
  ((next_wptr >= rptr_s2) ? 18'h00000 : cap2);
wire [17:0] rdiff = {1'b0, wptr_s2} - {1'b0, next_rptr} +
  ((wptr_s2 >= next_rptr) ? 18'h00000 : cap2);
wire [16:0] next_wcnt = wdiff[16:0];
wire [16:0] next_rcnt = rdiff[16:0];

always @(posedge ref_clk_i or negedge rstn_i) begin
  if (!rstn_i) begin
    wptr <= 17'h0;
    rptr <= 17'h0;
    wptr_s1 <= 17'h0;
    wptr_s2 <= 17'h0;
    rptr_s1 <= 17'h0;
    rptr_s2 <= 17'h0;
    wcnt <= 17'h0;
    full_o <= 1'b0;
    empty_o <= 1'b1;
    afull_o <= 1'b0;
    aempty_o <= 1'b1;
    casc_fwr_o <= 1'b0;
    casc_frdy_o <= 1'b0;
  end else if (ctrl[`DPBRF_C_FRST] | ~fifo) begin
    wptr <= 17'h0;
    rptr <= 17'h0;
    wptr_s1 <= 17'h0;
    wptr_s2 <= 17'h0;
    rptr_s1 <= 17'h0;
    rptr_s2 <= 17'h0;
    wcnt <= 17'h0;
    full_o <= 1'b0;
    empty_o <= 1'b1;
    afull_o <= 1'b0;
    aempty_o <= 1'b1;
    casc_fwr_o <= 1'b0;
    casc_frdy_o <= 1'b0;
  end else begin
    wptr <= next_wptr;
    rptr <= next_rptr;
    wptr_s1 <= wptr; // RULE23
    wptr_s2 <= wptr_s1; // RULE23
    rptr_s1 <= rptr; // RULE23
    rptr_s2 <= rptr_s1; // RULE23
    wcnt <= next_wcnt;
    // RULE18 RULE23
    full_o <= ({1'b0, next_wcnt} + {11'h0, a_w}) > {1'b0, cap};
    empty_o <= next_rcnt < {10'h0, b_w}; // RULE18 RULE23
    afull_o <= next_wcnt >= {1'b0, thr_af}; // RULE19
    aempty_o <= next_rcnt <= {1'b0, thr_ae}; // RULE19
    casc_fwr_o <= frd_ok & fcout; // RULE21
    casc_frdy_o <= ({1'b0, next_wcnt} + {10'h0, a_w, 1'b0}) <=
      {1'b0, cap}; // RULE21
  end
end

////////////////////////////////////////////////////////////////////////////
// Stand-alone codec for external memory

reg [65:0] ext_dec;

always @* begin
  ext_dec = ecc_dec(ecc_dec_i);
end

always @(posedge ref_clk_i or negedge rstn_i) begin
  if (!rstn_i) begin
    ecc_enc_c_o <= 8'h00;
    ecc_dec_o <= 64'h0;
    ecc_dec_sbe_o <= 1'b0;
    ecc_dec_dbe_o <= 1'b0;
  end else begin
    ecc_enc_c_o <= ecc_chk(ecc_enc_d_i); // RULE15
    ecc_dec_o <= ext_dec[63:0]; // RULE15
    ecc_dec_sbe_o <= ext_dec[64]; // RULE22
    ecc_dec_dbe_o <= ext_dec[65]; // RULE22
  end
end

endmodule

`default_nettype wire

// ---- testbench/dpbrf_core_props.sv ----
/* Checker of the tile's port timing, bound to dpbrf_core.
   Assumes one rising-edge clock and an active-low reset. */
`timescale 1ns/1ns
`default_nettype none
module dpbrf_core_props (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // Inputs watched
  input wire logic reg_rd_i,
  input wire logic pwr_gate_i,
  input wire logic a_en_i,
  input wire logic b_en_i,
  input wire logic casc_frdy_i,
  input wire logic [63:0] ecc_enc_d_i,
  input wire logic [71:0] ecc_dec_i,
  // Outputs watched
  input wire logic [31:0] reg_rdata_o,
  input wire logic [71:0] a_dout_o,
  input wire logic [71:0] b_dout_o,
  input wire logic full_o,
  input wire logic empty_o,
  input wire logic casc_fwr_o,
  input wire logic [7:0] ecc_enc_c_o,
  input wire logic [63:0] ecc_dec_o,
  input wire logic ecc_dec_sbe_o,
  input wire logic ecc_dec_dbe_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  ////////////////////////////////////////////////////////////////////////
  chk_rdata_idle: assert property (
    !$past(reg_rd_i) |-> reg_rdata_o == 32'h0) else $error("rdata not idle");
  chk_gate_hold: assert property (
    pwr_gate_i [*4] |-> $stable(a_dout_o) && $stable(b_dout_o))
    else $error("dout moved while gated");
  chk_flag_excl: assert property (
    !(full_o && empty_o)) else $error("full and empty together");
  chk_empty_lag: assert property (
    $fell(empty_o) |-> $past(a_en_i, 4)) else $error("empty fell early");
  chk_full_lag: assert property (
    $fell(full_o) |-> $past(b_en_i, 4)) else $error("full fell early");
  chk_casc_push: assert property (
    casc_fwr_o |-> $past(casc_frdy_i) && !$past(empty_o))
    else $error("cascade push without room");
  chk_enc_zero: assert property (
    $past(ecc_enc_d_i) == 64'h0 |-> ecc_enc_c_o == 8'h0)
    else $error("check bits of zero");
  chk_dec_clean: assert property (
    $past(ecc_dec_i) == 72'h0 |->
      ecc_dec_o == 64'h0 && !ecc_dec_sbe_o && !ecc_dec_dbe_o)
    else $error("clean word flagged");
  chk_err_excl: assert property (
    !(ecc_dec_sbe_o && ecc_dec_dbe_o)) else $error("both error flags");
  cov_empty: cover property ($fell(empty_o));
  cov_full: cover property ($fell(full_o));
  cov_push: cover property (casc_fwr_o);
  cov_sbe: cover property (ecc_dec_sbe_o);
endmodule
bind dpbrf_core dpbrf_core_props i_props (.ref_clk_i, .rstn_i, .reg_rd_i,
  .pwr_gate_i, .a_en_i, .b_en_i, .casc_frdy_i, .ecc_enc_d_i, .ecc_dec_i,
  .reg_rdata_o, .a_dout_o, .b_dout_o, .full_o, .empty_o, .casc_fwr_o,
  .ecc_enc_c_o, .ecc_dec_o, .ecc_dec_sbe_o, .ecc_dec_dbe_o);
`default_nettype wire

// ---- testbench/dpbrf_fab_rd.sv ----
/* Fabric model on port B: memory reads on request, FIFO drain.
   Assumes out reg off while draining; data one edge after a read. */
`timescale 1ns/1ns
`default_nettype none
module dpbrf_fab_rd (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // Bench control
  input wire logic auto_i,
  input wire logic stall_i,
  input wire logic req_i,
  // Tile port B
  input wire logic empty_i,
  input wire logic [71:0] dout_i,
  output logic b_en_o
);
  logic run;
  logic took;
  logic [71:0] rx [0:1023];
  int rx_n;
  assign b_en_o = auto_i ? run : req_i;
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      run <= 1'b0;
      took <= 1'b0;
      rx_n <= 0;
    end else begin
      run <= auto_i && !stall_i;
      took <= b_en_o && !empty_i;
      if (took && auto_i) begin
        rx[rx_n] <= dout_i;
        rx_n <= rx_n + 1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- testbench/dual_port_block_ram_fifo_tb_top.sv ----
/* Self-checking bench of dpbrf_core with a port B fabric model.
   Assumes a 100 MHz clock and the register map of the tile. */
`timescale 1ns/1ns
`default_nettype none
module dual_port_block_ram_fifo_tb_top;
  logic ref_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h0;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic pwr_gate_i = 1'b0;
  logic a_en_i = 1'b0;
  logic a_we_i = 1'b0;
  logic [15:0] a_addr_i = 16'h0;
  logic [71:0] a_din_i = 72'h0;
  logic [15:0] b_addr_i = 16'h0;
  logic b_req = 1'b0;
  logic f_auto = 1'b0;
  logic f_stall = 1'b1;
  logic casc_frdy_i = 1'b0;
  logic [63:0] ecc_enc_d_i = 64'h0;
  logic [71:0] ecc_dec_i = 72'h0;
  wire [31:0] reg_rdata_o;
  wire [71:0] a_dout_o, b_dout_o, casc_b_o;
  wire full_o, empty_o, afull_o, aempty_o, casc_fwr_o, b_en_i, sleep_o;
  wire ecc_dec_sbe_o, ecc_dec_dbe_o, b_sbe_o, b_dbe_o;
  wire [7:0] ecc_enc_c_o;
  wire [63:0] ecc_dec_o;
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;
  logic [7:0] r_a [0:6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
  logic [31:0] r_d [0:6] = '{32'h0, 32'h55, 32'h8000, 32'h48, 32'ha, 32'h0,
    32'h0};
  ////////////////////////////////////////////////////////////////////////
  dpbrf_core i_dut (.ref_clk_i, .rstn_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .pwr_gate_i, .sleep_o,
    .a_en_i, .a_we_i, .a_addr_i, .a_din_i, .a_dout_o, .a_sbe_o(),
    .a_dbe_o(), .b_en_i, .b_we_i(1'b0), .b_addr_i, .b_din_i(72'h0),
    .b_dout_o, .b_sbe_o, .b_dbe_o, .full_o, .empty_o, .afull_o,
    .aempty_o, .casc_a_i(72'h0), .casc_b_i(72'h0), .casc_a_o(), .casc_b_o,
    .casc_fwr_i(1'b0), .casc_fwr_o, .casc_frdy_i, .casc_frdy_o(),
    .ecc_enc_d_i, .ecc_enc_c_o, .ecc_dec_i, .ecc_dec_o, .ecc_dec_sbe_o,
    .ecc_dec_dbe_o);
  dpbrf_fab_rd i_fab (.ref_clk_i, .rstn_i, .auto_i(f_auto),
    .stall_i(f_stall), .req_i(b_req), .empty_i(empty_o),
    .dout_i(b_dout_o), .b_en_o(b_en_i));
  ////////////////////////////////////////////////////////////////////////
  initial begin
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      $display("MISMATCH t=%0t timeout", $time);
      final_report();
    end
  end
  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [71:0] got, input logic [71:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rw(input logic [7:0] a, input logic [31:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask
  task automatic rr(input logic [7:0] a, output logic [31:0] d);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    @(posedge ref_clk_i);
    d = reg_rdata_o;
  endtask
  task automatic pa(input logic we, input logic [15:0] ad,
    input logic [71:0] d);
    a_en_i <= 1'b1;
    a_we_i <= we;
    a_addr_i <= ad;
    a_din_i <= d;
    @(posedge ref_clk_i);
    a_en_i <= 1'b0;
    a_we_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask
  task automatic pb(input logic [15:0] ad);
    b_req <= 1'b1;
    b_addr_i <= ad;
    @(posedge ref_clk_i);
    b_req <= 1'b0;
    @(posedge ref_clk_i);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d;
    logic [71:0] c;
    int i;
    int k;
    repeat (10) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    @(posedge ref_clk_i);
    chk(empty_o, 1'b1);
    chk(full_o, 1'b0);
    rw(8'h18, 32'hffffffff);
    for (i = 0; i < 7; i++) begin
      rr(r_a[i], d);
      chk(d, r_d[i]);
    end
    $display("test registers done");
    // Memory mode, x36 both ports
    pa(1'b1, 16'd5, {36'hfff000fff, 36'h9abcdef12});
    pb(16'd5);
    chk(b_dout_o, 72'h9abcdef12);
    for (k = 0; k < 3; k++) begin
      rw(8'h00, k << 4);
      pa(1'b1, 16'd10, 72'h111111111);
      pa(1'b1, 16'd9, 72'h222222222);
      pa(1'b0, 16'd10, 72'h0);
      pa(1'b1, 16'd9, 72'h333333333);
      chk(a_dout_o, k == 1 ? 72'h333333333 : k == 0 ? 72'h222222222 :
        72'h111111111);
    end
    rw(8'h00, 32'h8);
    pb(16'd9);
    chk(b_dout_o, 72'h9abcdef12);
    @(posedge ref_clk_i);
    chk(b_dout_o, 72'h333333333);
    rw(8'h00, 32'h0);
    pwr_gate_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    chk(sleep_o, 1'b1);
    pa(1'b1, 16'd5, 72'h0);
    pwr_gate_i <= 1'b0;
    pb(16'd5);
    chk(b_dout_o, 72'h9abcdef12);
    $display("test memory done");
    // FIFO filled past full, then drained with stalls
    rw(8'h00, 32'h2);
    rw(8'h08, 32'd36000);
    f_auto <= 1'b1;
    for (i = 0; i < 1030; i++) begin
      a_en_i <= 1'b1;
      a_din_i <= {36'hf0f0f0f0f, 4'h5, i[15:0], ~i[15:0]};
      @(posedge ref_clk_i);
    end
    a_en_i <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    chk(full_o, 1'b1);
    chk(afull_o, 1'b1);
    chk(aempty_o, 1'b0);
    for (k = 0; k < 3000 && i_fab.rx_n < 1024; k++) begin
      f_stall <= (k % 4 == 1);
      @(posedge ref_clk_i);
    end
    f_stall <= 1'b1;
    repeat (6) @(posedge ref_clk_i);
    chk(i_fab.rx_n, 1024);
    chk(empty_o, 1'b1);
    chk(aempty_o, 1'b1);
    for (i = 0; i < 1024; i++)
      chk(i_fab.rx[i], {36'h0, 4'h5, i[15:0], ~i[15:0]});
    $display("test fifo done");
    rw(8'h00, 32'h2002);
    casc_frdy_i <= 1'b1;
    a_en_i <= 1'b1;
    a_din_i <= 72'habcabcabc;
    @(posedge ref_clk_i);
    a_en_i <= 1'b0;
    for (k = 0; k < 20 && casc_fwr_o !== 1'b1; k++)
      @(posedge ref_clk_i);
    chk(casc_fwr_o, 1'b1);
    chk(casc_b_o, 72'habcabcabc);
    casc_frdy_i <= 1'b0;
    $display("test cascade done");
    ecc_enc_d_i <= 64'h0123456789abcdef;
    repeat (2) @(posedge ref_clk_i);
    c = {ecc_enc_c_o, 64'h0123456789abcdef};
    for (k = 0; k < 3; k++) begin
      ecc_dec_i <= c ^ (k == 0 ? 72'h0 : k == 1 ? 72'h10 : 72'h30);
      repeat (2) @(posedge ref_clk_i);
      if (k < 2)
        chk(ecc_dec_o, c[63:0]);
      chk(ecc_dec_sbe_o, k == 1);
      chk(ecc_dec_dbe_o, k == 2);
    end
    $display("test codec done");
    f_auto <= 1'b0;
    rw(8'h04, 32'h66);
    rw(8'h00, 32'h4);
    pa(1'b1, 16'd0, c ^ 72'h10);
    rw(8'h00, 32'h204);
    pb(16'd0);
    chk(b_dout_o, {8'h0, c[63:0]});
    chk(b_sbe_o, 1'b1);
    chk(b_dbe_o, 1'b0);
    $display("test wide ecc done");
    final_report();
  end
endmodule
`default_nettype wire
